// *** pfss_pkg.sv ***
// pfss_pkg: constants, register map and state type of the sequencer
// assumes a 10 MHz pclk; the sync module below is used by the sequencer
package pfss_pkg;
	// ==========================================
	// timing
	localparam int CLK_PERIOD_NS    = 100;
	localparam int BLANK_TIME_NS    = 250;
	localparam int BLANK_CYC        = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FAULT_TIME_MS    = 100;
	localparam int FAULT_CYC        = FAULT_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int SOFT_START_US    = 5000;
	localparam int SOFT_START_CYC   = SOFT_START_US * 1000 / CLK_PERIOD_NS;
	localparam int SWITCH_FREQ_KHZ  = 65;
	localparam int SWITCH_CYC       = 1000000 / (SWITCH_FREQ_KHZ * CLK_PERIOD_NS);
	localparam int SS_LEVEL_W       = 8;
	localparam int SS_STEPS         = 256;
	// ==========================================
	// register map
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_INT_STAT = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK = 8'h0C;
	localparam int         CTRL_DRV_EN   = 0;
	localparam logic       CTRL_RESET    = 1'h1;
	localparam int         ST_STATE_LSB  = 0;
	localparam int         ST_SKIP       = 3;
	localparam int         ST_AUX        = 4;
	localparam int         ST_FLAG       = 5;
	localparam int         ST_STARTUP    = 6;
	localparam int         INT_W         = 4;
	localparam int         INT_FAULT     = 0;
	localparam int         INT_LATCH     = 1;
	localparam int         INT_AUX_ON    = 2;
	localparam int         INT_SKIP      = 3;
	localparam logic [3:0] INT_MASK_RST  = 4'h0;
	// ==========================================
	// sequencer states
	typedef enum logic [2:0] {
		PFSS_OFF,
		PFSS_SOFT,
		PFSS_RUN,
		PFSS_FAULT,
		PFSS_LATCH
	} pfss_state_t;
endpackage

// *** pfss_sync.sv ***
// pfss_sync: two-flop synchroniser for the comparator outputs
// assumes inputs change freely with respect to pclk
`timescale 1ns/1ps
module pfss_sync
	import pfss_pkg::*;
#(
	parameter int W = 6
)(
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         ce,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// ==========================================
	// two stages, first read only by the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta <= '0;
			q    <= '0;
		end
		else if (ce)
		begin
			meta <= d;    // [RULE17]
			q    <= meta; // [RULE17]
		end
	end
endmodule

// *** pfss_sequencer.sv ***
// pfss_sequencer: startup, soft-start, fault timer and drive sequencing
// assumes comparator levels arrive asynchronous and APB runs on pclk
//
// Overview of operation
// RULE1 - ignore current-sense trip for the blanking time after each pulse starts
// RULE2 - fault timer starts as soon as the clamp error flag is high
// RULE3 - flag still high at timer end: genuine fault, drive stops
// RULE4 - supply below low lockout threshold: latch-off, drive off, low power
// RULE5 - from latch-off, start threshold brings soft-start and normal startup
// RULE6 - flag dropping before timer end clears the timer, no fault
// RULE7 - timer end in skip mode opens the aux switch until restart completes
// RULE8 - lockout enters latch-off at once, no timer or flag needed
// RULE9 - drive stays off after power-up until start threshold is reached
// RULE10 - peak current at clamp level limits pulse and raises error flag
// RULE11 - startup: flag drops before timer end, timer clears, aux switch closes
// RULE12 - startup: flag still high at timer end, enter skip, switch open
// RULE13 - soft-start ramps the peak limit from zero to full over its period
// RULE14 - soft-start runs on every restart, not only the first
// RULE15 - system designer keeps skip burst duty below the stated fraction
// RULE16 - feedback above skip-exit level leaves skip, switch closes at once
// RULE17 - all comparator outputs are synchronised before use
`timescale 1ns/1ps
module pfss_sequencer
	import pfss_pkg::*;
#(
	parameter int FAULT_CYC_P = FAULT_CYC,
	parameter int SS_CYC_P    = SOFT_START_CYC
)(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  ce,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic                  cs_trip_in,
	input  wire logic                  clamp_flag_in,
	input  wire logic                  vcc_start_in,
	input  wire logic                  undervoltage_lockout_low,
	input  wire logic                  skip_cmp_in,
	input  wire logic                  skip_exit_in,
	output logic                       gate_drive_output,
	output logic                       aux_supply_switch,
	output logic [SS_LEVEL_W-1:0]      soft_start_level,
	output logic                       error_flag,
	output logic                       latch_off_lowpower,
	output logic                       irq
);
	localparam int SS_STEP = (SS_CYC_P / SS_STEPS > 0) ? SS_CYC_P / SS_STEPS : 1;

	function automatic logic is_active(input pfss_state_t s);
		return (s == PFSS_SOFT) || (s == PFSS_RUN);
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		return (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_INT_STAT) || (a == ADDR_INT_MASK);
	endfunction

	pfss_state_t      state;
	logic [5:0]       sync_q;
	logic             cs_s, clamp_s, start_s, uvlo_s, skip_s, exit_s;
	logic [19:0]      fault_cnt;
	logic [15:0]      ss_cnt;
	logic [7:0]       period_cnt;
	logic [1:0]       blank_cnt;
	logic             startup, clamp_seen, skip_mode;
	logic             ctrl_en;
	logic [INT_W-1:0] int_stat, int_mask, ev;
	logic             active, drive_en, expire, ev_restart, ev_latch, ev_close, ev_exit;
	logic             wr_en, period_end;

	// ==========================================
	// input synchronisers
	pfss_sync #(.W(6)) u_pfss_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.d       ({cs_trip_in, clamp_flag_in, vcc_start_in, undervoltage_lockout_low, skip_cmp_in, skip_exit_in}),
		.q       (sync_q)
	);
	assign {cs_s, clamp_s, start_s, uvlo_s, skip_s, exit_s} = sync_q; // [RULE17]

	// ==========================================
	// sequencing events
	assign active     = is_active(state);
	assign drive_en   = active && ctrl_en;
	assign expire     = active && !uvlo_s && clamp_s && (fault_cnt == 20'(FAULT_CYC_P - 1)); // [RULE3]
	assign ev_restart = ((state == PFSS_OFF) || (state == PFSS_LATCH)) && start_s && !uvlo_s;
	assign ev_latch   = (state != PFSS_OFF) && (state != PFSS_LATCH) && uvlo_s; // [RULE8]
	assign ev_close   = active && !uvlo_s && startup && !clamp_s && (clamp_seen || state == PFSS_RUN);
	assign ev_exit    = active && !uvlo_s && skip_mode && exit_s && !expire;
	assign period_end = (period_cnt == 8'(SWITCH_CYC - 1));
	assign ev         = {expire && startup, ev_close || ev_exit, ev_latch, expire && !startup};

	// ==========================================
	// state machine
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= PFSS_OFF;
		else if (ce)
		begin
			case (state)
				PFSS_OFF:
					if (ev_restart)
						state <= PFSS_SOFT; // [RULE9]
				PFSS_SOFT, PFSS_RUN:
					if (uvlo_s)
						state <= PFSS_LATCH; // [RULE4] [RULE8]
					else if (expire && !startup)
						state <= PFSS_FAULT; // [RULE3]
					else if (state == PFSS_SOFT && ss_cnt == 16'(SS_STEP - 1) && &soft_start_level)
						state <= PFSS_RUN;
				PFSS_FAULT:
					if (uvlo_s)
						state <= PFSS_LATCH; // [RULE4]
				PFSS_LATCH:
					if (ev_restart)
						state <= PFSS_SOFT; // [RULE5] [RULE14]
				default:
					state <= PFSS_OFF;
			endcase
		end
	end

	// ==========================================
	// fault timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fault_cnt <= '0;
		else if (ce)
		begin
			if (!active || !clamp_s || expire)
				fault_cnt <= '0; // [RULE6] [RULE11]
			else
				fault_cnt <= fault_cnt + 20'h00001; // [RULE2]
		end
	end

	// ==========================================
	// startup phase, skip mode and aux switch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			startup    <= 1'b0;
			clamp_seen <= 1'b0;
		end
		else if (ce)
		begin
			if (ev_restart)
			begin
				startup    <= 1'b1;
				clamp_seen <= 1'b0;
			end
			else
			begin
				if (ev_latch || ev_close || expire)
					startup <= 1'b0;
				if (active && clamp_s)
					clamp_seen <= 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			skip_mode <= 1'b0;
		else if (ce)
		begin
			if (ev_restart || ev_latch || ev_exit)
				skip_mode <= 1'b0; // [RULE16]
			else if (expire)
				skip_mode <= startup; // [RULE12]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			aux_supply_switch <= 1'b0;
		else if (ce)
		begin
			if (ev_restart || ev_latch || expire || !active)
				aux_supply_switch <= 1'b0; // [RULE7] [RULE12]
			else if (ev_close || ev_exit)
				aux_supply_switch <= 1'b1; // [RULE11] [RULE16]
		end
	end

	// ==========================================
	// soft-start ramp
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ss_cnt           <= '0;
			soft_start_level <= '0;
		end
		else if (ce)
		begin
			if (ev_restart || !active)
			begin
				ss_cnt           <= '0;
				soft_start_level <= '0; // [RULE14]
			end
			else if (state == PFSS_SOFT)
			begin
				if (ss_cnt == 16'(SS_STEP - 1))
				begin
					ss_cnt <= '0;
					if (!(&soft_start_level))
						soft_start_level <= soft_start_level + 8'h01; // [RULE13]
				end
				else
					ss_cnt <= ss_cnt + 16'h0001;
			end
		end
	end

	// ==========================================
	// switching period, blanking and gate drive
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_cnt <= '0;
		else if (ce)
			period_cnt <= period_end ? 8'h00 : period_cnt + 8'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gate_drive_output <= 1'b0;
			blank_cnt         <= '0;
		end
		else if (ce)
		begin
			if (!drive_en || period_end)
				gate_drive_output <= 1'b0; // [RULE3] [RULE9]
			else if (period_cnt == 8'h00 && !skip_s)
			begin
				gate_drive_output <= 1'b1;
				blank_cnt         <= 2'(BLANK_CYC); // [RULE1]
			end
			else if (blank_cnt != 2'h0)
				blank_cnt <= blank_cnt - 2'h1; // [RULE1]
			else if (cs_s || clamp_s)
				gate_drive_output <= 1'b0; // [RULE10]
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			error_flag         <= 1'b0;
			latch_off_lowpower <= 1'b0;
		end
		else if (ce)
		begin
			error_flag         <= active && clamp_s; // [RULE10]
			latch_off_lowpower <= (state == PFSS_LATCH); // [RULE4]
		end
	end

	// ==========================================
	// APB slave, no wait states
	assign wr_en = psel && penable && pready && pwrite;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end
		else if (ce)
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_ok(paddr);
			prdata  <= '0;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					ADDR_CTRL:     prdata[CTRL_DRV_EN] <= ctrl_en;
					ADDR_STATUS:
					begin
						prdata[ST_STATE_LSB +: 3] <= state;
						prdata[ST_SKIP]           <= skip_mode;
						prdata[ST_AUX]            <= aux_supply_switch;
						prdata[ST_FLAG]           <= error_flag;
						prdata[ST_STARTUP]        <= startup;
					end
					ADDR_INT_STAT: prdata[INT_W-1:0] <= int_stat;
					ADDR_INT_MASK: prdata[INT_W-1:0] <= int_mask;
					default:       prdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_en  <= CTRL_RESET;
			int_mask <= INT_MASK_RST;
		end
		else if (ce && wr_en)
		begin
			if (paddr == ADDR_CTRL)
				ctrl_en <= pwdata[CTRL_DRV_EN];
			if (paddr == ADDR_INT_MASK)
				int_mask <= pwdata[INT_W-1:0];
		end
	end

	// ==========================================
	// interrupts: set wins over write-one-to-clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_stat <= '0;
			irq      <= 1'b0;
		end
		else if (ce)
		begin
			int_stat <= (int_stat & ~((wr_en && paddr == ADDR_INT_STAT) ? pwdata[INT_W-1:0] : 4'h0)) | ev;
			irq      <= |(int_stat & int_mask);
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_blank_hold: assert property (gate_drive_output && blank_cnt != 2'h0 && ce && drive_en && !period_end
		|=> gate_drive_output) else $error("pulse ended inside blanking"); // [RULE1]
	a_timer_start: assert property (ce && active && !uvlo_s && clamp_s && fault_cnt == 20'h0
		|=> fault_cnt == 20'h00001) else $error("fault timer did not start"); // [RULE2]
	a_fault_stop: assert property ($past(state) == PFSS_FAULT && state == PFSS_FAULT
		|-> !gate_drive_output) else $error("drive active during fault"); // [RULE3]
	a_uvlo_latch: assert property (ce && uvlo_s && is_active(state)
		|=> state == PFSS_LATCH ##1 !gate_drive_output) else $error("lockout did not latch off"); // [RULE8]
	a_restart_soft: assert property (ce && state == PFSS_LATCH && start_s && !uvlo_s
		|=> state == PFSS_SOFT && soft_start_level == 8'h00) else $error("restart without soft-start"); // [RULE5]
	a_timer_clear: assert property (ce && !clamp_s
		|=> fault_cnt == 20'h0) else $error("timer kept after flag drop"); // [RULE6]
	a_expire_open: assert property (ce && expire
		|=> !aux_supply_switch) else $error("aux switch closed after expiry"); // [RULE7]
	a_first_off: assert property (state == PFSS_OFF
		|-> !gate_drive_output && !aux_supply_switch) else $error("drive before start threshold"); // [RULE9]
	a_startup_close: assert property (ce && ev_close && !expire
		|=> aux_supply_switch && !startup) else $error("startup did not close switch"); // [RULE11]
	a_startup_skip: assert property (ce && expire && startup
		|=> skip_mode && !aux_supply_switch && state != PFSS_FAULT) else $error("startup expiry not skip"); // [RULE12]
	a_ss_ramp: assert property (state == PFSS_SOFT && $past(state) == PFSS_SOFT
		|-> soft_start_level >= $past(soft_start_level)) else $error("soft-start level fell"); // [RULE13]
	a_skip_exit: assert property (ce && ev_exit
		|=> aux_supply_switch && !skip_mode) else $error("skip exit did not close switch"); // [RULE16]

	c_fault: cover property (state == PFSS_RUN ##1 state == PFSS_FAULT);
	c_close: cover property (ev_close && ce ##1 aux_supply_switch);
	c_skip_exit: cover property (skip_mode ##1 !skip_mode && aux_supply_switch);
	c_restart: cover property (state == PFSS_LATCH ##1 state == PFSS_SOFT);
endmodule

// *** pfss_power_stage.sv ***
// pfss_power_stage: behavioural power switch and current-sense path driven by the gate
// assumes one pclk domain; the gate input is the sequencer's drive output
`timescale 1ns/1ps
module pfss_power_stage
(
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       gate,
	input  wire logic [7:0] ramp_cyc,
	output logic            cs_trip
);
	// ==========================================
	// on-time counter
	logic [7:0] on_cnt;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			on_cnt <= 8'h00;
		else if (!gate)
			on_cnt <= 8'h00;
		else if (on_cnt != 8'hFF)
			on_cnt <= on_cnt + 8'h01;
	end

	// ==========================================
	// comparator: turn-on spike in the first cycle, then the ramp reaches the setpoint
	assign cs_trip = gate && (on_cnt == 8'h00 || on_cnt >= ramp_cyc);
endmodule

// *** test_pwm_fault_startup_sequencer.sv ***
// test_pwm_fault_startup_sequencer: self-checking bench for the sequencer
// assumes pfss_pkg, pfss_sync, pfss_sequencer and pfss_power_stage are compiled first
`timescale 1ns/1ps
module test_pwm_fault_startup_sequencer;
	import pfss_pkg::*;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, soft_start_level, ramp;
	logic [31:0] pwdata, prdata, rd;
	logic        cs_trip_in, clamp_flag_in, vcc_start_in, undervoltage_lockout_low, skip_cmp_in, skip_exit_in;
	logic        gate_drive_output, aux_supply_switch, error_flag, latch_off_lowpower, irq, er;
	int          n_errors, num_checks, cyc, i, w, k;

	pfss_sequencer #(.FAULT_CYC_P(200), .SS_CYC_P(512)) u_pfss_sequencer (.pclk, .presetn, .ce, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cs_trip_in, .clamp_flag_in,
		.vcc_start_in, .undervoltage_lockout_low, .skip_cmp_in, .skip_exit_in, .gate_drive_output,
		.aux_supply_switch, .soft_start_level, .error_flag, .latch_off_lowpower, .irq);
	pfss_power_stage u_pfss_power_stage (.pclk, .presetn, .gate(gate_drive_output), .ramp_cyc(ramp),
		.cs_trip(cs_trip_in));

	// ==========================================
	// clock and hang guard
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			report_and_stop;
		end
	end

	// ==========================================
	// helpers
	// pulse length: ramp cycles plus two sync stages and the drive register, with slack
	function automatic logic width_ok(input int seen, input logic [7:0] r);
		return (seen >= int'(r)) && (seen <= int'(r) + 6);
	endfunction

	task report_and_stop;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, exp, got);
		end
	endtask

	task clk(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task stat;
		apb(1'b0, ADDR_STATUS, 32'h0);
	endtask

	task count_gate(input int n);
		w = 0;
		repeat (n)
		begin
			@(posedge pclk);
			if (gate_drive_output === 1'b1)
				w++;
		end
	endtask

	task pulse_width;
		ramp <= 8'($urandom_range(20, 60));
		for (i = 0; i < 400 && gate_drive_output !== 1'b0; i++) @(posedge pclk);
		for (i = 0; i < 400 && gate_drive_output !== 1'b1; i++) @(posedge pclk);
		for (w = 0; w < 200 && gate_drive_output === 1'b1; w++) @(posedge pclk);
		chk("pulse_width", 32'(width_ok(w, ramp)), 32'h1);
	endtask

	task startup;
		undervoltage_lockout_low <= 1'b0;
		vcc_start_in <= 1'b1;
		clk(5);
		chk("ss_level_start", 32'(soft_start_level <= 8'h02), 32'h1);
		stat;
		chk("state_soft", 32'(rd[2:0]), 32'h1);
	endtask

	task lockout;
		undervoltage_lockout_low <= 1'b1;
		vcc_start_in <= 1'b0;
		clk(6);
		chk("lowpower", 32'(latch_off_lowpower), 32'h1);
		chk("gate_latch", 32'(gate_drive_output), 32'h0);
		stat;
		chk("state_latch", 32'(rd[2:0]), 32'h4);
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, clamp_flag_in, vcc_start_in} = '0;
		{undervoltage_lockout_low, skip_cmp_in, skip_exit_in} = '0;
		ce = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		ramp = 8'h28;
		n_errors = 0;
		num_checks = 0;
		cyc = 0;
		void'($urandom(61));
		clk(5);
		presetn <= 1'b1;
		clk(20);
		chk("gate_off", 32'(gate_drive_output), 32'h0);
		chk("aux_off", 32'(aux_supply_switch), 32'h0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl_rst", rd, 32'h1);
		apb(1'b0, ADDR_INT_MASK, 32'h0);
		chk("mask_rst", rd, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped_err", 32'(er), 32'h1);
		apb(1'b1, ADDR_INT_MASK, 32'h4);
		startup;
		clk(100);
		chk("ss_ramp", 32'(soft_start_level > 8'h00 && soft_start_level < 8'hFF), 32'h1);
		ce <= 1'b0;
		clk(1);
		rd = 32'(soft_start_level);
		clk(30);
		chk("ce_freeze", 32'(soft_start_level), rd);
		ce <= 1'b1;
		pulse_width;
		clamp_flag_in <= 1'b1;
		clk(50);
		clamp_flag_in <= 1'b0;
		clk(6);
		chk("aux_close", 32'(aux_supply_switch), 32'h1);
		chk("irq_aux", 32'(irq), 32'h1);
		stat;
		chk("no_fault", 32'(rd[2:0] != 3'h3), 32'h1);
		apb(1'b1, ADDR_INT_STAT, 32'hF);
		clk(3);
		chk("irq_clear", 32'(irq), 32'h0);
		apb(1'b1, ADDR_INT_MASK, 32'h1);
		for (k = 0; k < 100; k++)
		begin
			stat;
			if (rd[2:0] === 3'h2)
				break;
			clk(10);
		end
		chk("state_run", 32'(rd[2:0]), 32'h2);
		chk("ss_full", 32'(soft_start_level), 32'hFF);
		repeat (6)
		begin
			clamp_flag_in <= 1'b1;
			clk($urandom_range(10, 180));
			clamp_flag_in <= 1'b0;
			clk(20);
		end
		stat;
		chk("transient_run", 32'(rd[2:0]), 32'h2);
		apb(1'b1, ADDR_CTRL, 32'h0);
		clk(2);
		count_gate(200);
		chk("gate_disabled", 32'(w), 32'h0);
		apb(1'b1, ADDR_CTRL, 32'h1);
		pulse_width;
		clamp_flag_in <= 1'b1;
		clk(190);
		stat;
		chk("timer_not_yet", 32'(rd[2:0]), 32'h2);
		chk("error_flag", 32'(error_flag), 32'h1);
		clk(20);
		stat;
		chk("state_fault", 32'(rd[2:0]), 32'h3);
		clamp_flag_in <= 1'b0;
		count_gate(300);
		chk("gate_fault", 32'(w), 32'h0);
		chk("aux_fault", 32'(aux_supply_switch), 32'h0);
		chk("irq_fault", 32'(irq), 32'h1);
		apb(1'b1, ADDR_INT_STAT, 32'hF);
		lockout;
		chk("irq_masked", 32'(irq), 32'h0);
		for (k = 0; k < 2; k++)
		begin
			startup;
			clamp_flag_in <= 1'b1;
			clk(250);
			stat;
			chk("skip_mode", 32'(rd[3]), 32'h1);
			chk("aux_open_skip", 32'(aux_supply_switch), 32'h0);
			if (k == 0)
			begin
				clamp_flag_in <= 1'b0;
				skip_cmp_in <= 1'b1;
				// let a pulse launched before the skip input was synchronised run out
				clk(70);
				count_gate(320);
				chk("skip_blank", 32'(w), 32'h0);
				skip_cmp_in <= 1'b0;
				chk("aux_stays_open", 32'(aux_supply_switch), 32'h0);
				skip_exit_in <= 1'b1;
				clk(4);
				chk("aux_exit", 32'(aux_supply_switch), 32'h1);
				skip_exit_in <= 1'b0;
				lockout;
			end
			else
			begin
				clk(215);
				stat;
				chk("skip_fault", 32'(rd[2:0]), 32'h3);
				chk("aux_skip_fault", 32'(aux_supply_switch), 32'h0);
				clamp_flag_in <= 1'b0;
			end
		end
		report_and_stop;
	end
endmodule
